// ==== inc/flash_cmd_defs.svh ====
/*
 * opcode values, status and security bit positions, frame byte counts and
 * reset values of the serial flash command decoder.
 * assumes: included by bare name by the design files.
 */
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

// opcodes, first byte of a frame
`define OPC_WRITE_LATCH_ARM   8'h06
`define OPC_WRITE_LATCH_CLEAR 8'h04
`define OPC_STATUS_WRITE      8'h01
`define OPC_STATUS_READ       8'h05
`define OPC_JEDEC_ID_READ     8'h9f
`define OPC_ARRAY_READ        8'h03
`define OPC_FAST_READ         8'h0b
`define OPC_DUAL_READ         8'h3b
`define OPC_WAKE_SIGNATURE    8'hab
`define OPC_MAKER_PART_ID     8'h90
`define OPC_FOUR_KIB_WIPE     8'h20
`define OPC_BLOCK_WIPE_A      8'h52
`define OPC_BLOCK_WIPE_B      8'hd8
`define OPC_CHIP_WIPE_A       8'h60
`define OPC_CHIP_WIPE_B       8'hc7
`define OPC_PAGE_WRITE        8'h02
`define OPC_DEEP_POWER_DOWN   8'hb9
`define OPC_LOCKDOWN_READ     8'h2b
`define OPC_LOCKDOWN_BIT      8'h2f
`define OPC_OTP_ENTRY         8'hb1
`define OPC_OTP_EXIT          8'hc1

// status register: write latch position
`define STAT_WRITE_LATCH_BIT  1
// security register: factory lock at bit 0, customer lock at bit 1
`define SEC_FACTORY_BIT       0
`define SEC_CUSTOMER_BIT      1

// address bytes after the opcode, index of the last one
`define ADDR_LAST_BYTE        2'd2
// last jedec id byte index
`define JEDEC_LAST_IDX        2'd2
// value sent when the read fifo has no byte
`define READ_UNDERRUN_BYTE    8'hff
// reset values
`define WRITE_LATCH_RST       1'b0
`define LOCKDOWN_RST          1'b0

`endif

// ==== inc/flash_cmd_pkg.sv ====
/*
 * types shared by the serial flash command decoder: decoder states,
 * the operation record handed to the array side.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package flash_cmd_pkg;

	// decoder states within one chip-select frame
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_OPC,
		ST_ADDR,
		ST_DUMMY,
		ST_DOUT,
		ST_DIN,
		ST_TAIL,
		ST_IGNORE
	} dec_state_e;

	// operation kinds requested from the array side
	typedef enum logic [2:0]
	{
		OP_READ,
		OP_FAST_READ,
		OP_DUAL_READ,
		OP_PAGE_WRITE,
		OP_SECTOR_WIPE,
		OP_BLOCK_WIPE,
		OP_CHIP_WIPE
	} op_kind_e;

	// operation record
	typedef struct packed
	{
		op_kind_e    kind;
		logic        otp;
		logic [23:0] addr;
	} op_s;

endpackage : flash_cmd_pkg

// ==== rtl/byte_fifo.sv ====
/*
 * byte_fifo: small synchronous fifo with a registered output stage.
 * assumes: one clock, synchronous active-low reset, flush clears content.
 */
`timescale 1ns/1ps
`include "flash_cmd_defs.svh"

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             flush_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	// refuse shapes the pointer arithmetic cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad_shape
		$error("byte_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];  // storage
	logic [AW-1:0]    wr_ptr_r;       // write pointer
	logic [AW-1:0]    rd_ptr_r;       // read pointer
	logic [AW:0]      cnt_r;          // words held in storage
	logic [WIDTH-1:0] out_data_r;     // output register
	logic             out_valid_r;    // output register full
	logic [AW-1:0]    wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_nxt;
	logic [AW:0]      cnt_nxt;
	logic             out_valid_nxt;
	logic             push;
	logic             refill;

	// full once storage and output stage together hold DEPTH words
	assign in_ready_o  = ((AW+1)'(cnt_r + out_valid_r) != (AW+1)'(DEPTH));
	assign out_data_o  = out_data_r;
	assign out_valid_o = out_valid_r;

	// pointer, count and output-stage next values
	always_comb
	begin
		push          = in_valid_i && in_ready_o;
		refill        = (!out_valid_r || out_ready_i) && (cnt_r != '0);
		wr_ptr_nxt    = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
		rd_ptr_nxt    = refill ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
		cnt_nxt       = (AW+1)'(cnt_r + (push ? 1'b1 : 1'b0) - (refill ? 1'b1 : 1'b0));
		out_valid_nxt = refill ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_r);
		if (flush_i)
		begin
			wr_ptr_nxt    = '0;
			rd_ptr_nxt    = '0;
			cnt_nxt       = '0;
			out_valid_nxt = 1'b0;
		end
	end

	// control registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_r    <= '0;
			rd_ptr_r    <= '0;
			cnt_r       <= '0;
			out_valid_r <= 1'b0;
		end
		else
		begin
			wr_ptr_r    <= wr_ptr_nxt;
			rd_ptr_r    <= rd_ptr_nxt;
			cnt_r       <= cnt_nxt;
			out_valid_r <= out_valid_nxt;
		end
	end

	// storage and registered read data
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
		if (refill)
			out_data_r <= mem_r[rd_ptr_r];
	end

endmodule : byte_fifo

// ==== rtl/flash_cmd_decoder.sv ====
/*
 * flash_cmd_decoder: opcode interpreter of a serial nor flash, oversampling
 * the spi pins on sys_clk_i; keeps write latch, lock-down, otp and power state.
 * assumes: sys_clk_i at least 8x the serial clock; the array side answers
 * read requests through the read fifo and executes the issued operations.
 */
`timescale 1ns/1ps
`include "flash_cmd_defs.svh"

module flash_cmd_decoder
	import flash_cmd_pkg::*;
#(
	parameter logic [7:0] ID_MAKER = 8'h5a,  // arbitrary value
	parameter logic [7:0] ID_TYPE  = 8'h20,  // arbitrary value
	parameter logic [7:0] ID_CAP   = 8'h15,  // arbitrary value
	parameter logic [7:0] ID_PART  = 8'h14,  // arbitrary value
	parameter logic [7:0] ID_SIG   = 8'h14,  // arbitrary value
	parameter int         FIFO_DEPTH = 16
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       cs_n_i,
	input  wire logic       sclk_i,
	input  wire logic       si_i,
	output logic            so_o,
	output logic            so_oe_o,
	output logic            sio0_o,
	output logic            sio0_oe_o,
	input  wire logic       factory_lock_i,
	input  wire logic [7:0] status_ext_i,
	output logic            write_latch_o,
	output logic            lockdown_o,
	output logic            otp_mode_o,
	output logic            deep_pd_o,
	output op_s             op_o,
	output logic            op_valid_o,
	output logic [7:0]      prog_data_o,
	output logic            prog_valid_o,
	output logic            status_wr_o,
	output logic [7:0]      status_data_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i,
	output logic            rd_ready_o
);
	// pin synchronisers: [0] first stage, [1] second, [2] edge history
	logic [2:0]  cs_sync_r;
	logic [2:0]  sclk_sync_r;
	logic [1:0]  si_sync_r;
	logic        cs_fall;     // frame start
	logic        cs_rise;     // frame end
	logic        sclk_rise;   // input sampling edge
	logic        sclk_fall;   // output shifting edge
	logic        byte_done;   // eighth bit of a byte sampled
	logic [7:0]  sh_full;     // byte including the bit sampled now
	logic        exec;        // frame ends on a byte boundary with command whole
	// decoder state
	dec_state_e  state_r, state_nxt;
	logic [2:0]  bit_cnt_r, bit_cnt_nxt;
	logic [1:0]  byte_cnt_r, byte_cnt_nxt;
	logic [7:0]  sh_in_r, sh_in_nxt;
	logic [7:0]  opc_r, opc_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic        done_r, done_nxt;        // required bytes received
	logic [7:0]  out_sh_r, out_sh_nxt;
	logic [2:0]  obit_r, obit_nxt;
	logic [1:0]  idx_r, idx_nxt;          // id byte index
	logic        so_r, so_nxt;
	logic        sio0_r, sio0_nxt;
	logic        drive_r, drive_nxt;
	logic        dual_r, dual_nxt;
	// device state
	logic        wl_r, wl_nxt;            // write latch
	logic        lock_r, lock_nxt;        // customer lock-down bit
	logic        otp_r, otp_nxt;
	logic        pd_r, pd_nxt;
	logic [7:0]  wsr_r, wsr_nxt;
	logic        swr_r, swr_nxt;
	op_s         op_r, op_nxt;
	logic        opv_r, opv_nxt;
	logic [7:0]  pdat_r, pdat_nxt;
	logic        pval_r, pval_nxt;
	// read fifo face
	logic [7:0]  fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;
	logic [7:0]  next_byte;

	// read data buffer between array side and serial output
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
		.clk_i       (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (cs_fall),
		.in_data_i   (rd_data_i),
		.in_valid_i  (rd_valid_i),
		.in_ready_o  (rd_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);

	// edge finding on second and history stages only
	assign cs_fall   = cs_sync_r[2] && !cs_sync_r[1];
	assign cs_rise   = !cs_sync_r[2] && cs_sync_r[1];
	assign sclk_rise = !cs_sync_r[1] && !sclk_sync_r[2] && sclk_sync_r[1];
	assign sclk_fall = !cs_sync_r[1] && sclk_sync_r[2] && !sclk_sync_r[1];
	assign byte_done = sclk_rise && (bit_cnt_r == 3'd7);
	assign sh_full   = {sh_in_r[6:0], si_sync_r[1]};
	// only ab is honoured in power-down; boundary checked on select rise
	assign exec = cs_rise && (bit_cnt_r == 3'd0) && done_r
		&& (!pd_r || opc_r == `OPC_WAKE_SIGNATURE);

	// byte presented at the next output load
	always_comb
	begin
		fifo_pop  = 1'b0;
		next_byte = 8'h00;
		case (opc_r)
			`OPC_STATUS_READ:
			begin
				next_byte = status_ext_i;
				next_byte[`STAT_WRITE_LATCH_BIT] = wl_r;
			end
			`OPC_JEDEC_ID_READ:
				next_byte = (idx_r == 2'd0) ? ID_MAKER : ((idx_r == 2'd1) ? ID_TYPE : ID_CAP);
			`OPC_MAKER_PART_ID:
				next_byte = (idx_r[0] ^ addr_r[0]) ? ID_PART : ID_MAKER;
			`OPC_WAKE_SIGNATURE:
				next_byte = ID_SIG;
			`OPC_LOCKDOWN_READ:
			begin
				next_byte[`SEC_FACTORY_BIT]  = factory_lock_i;
				next_byte[`SEC_CUSTOMER_BIT] = lock_r;
			end
			default:
			begin
				// array reads take from the fifo
				next_byte = fifo_valid ? fifo_data : `READ_UNDERRUN_BYTE;
				fifo_pop  = sclk_fall && (state_r == ST_DOUT) && (obit_r == 3'd0) && fifo_valid;
			end
		endcase
	end

	// decoder and device next-state logic
	always_comb
	begin
		state_nxt = state_r;    bit_cnt_nxt = bit_cnt_r;  byte_cnt_nxt = byte_cnt_r;
		sh_in_nxt = sh_in_r;    opc_nxt = opc_r;          addr_nxt = addr_r;
		done_nxt = done_r;      out_sh_nxt = out_sh_r;    obit_nxt = obit_r;
		idx_nxt = idx_r;        so_nxt = so_r;            sio0_nxt = sio0_r;
		drive_nxt = drive_r;    dual_nxt = dual_r;        wl_nxt = wl_r;
		lock_nxt = lock_r;      otp_nxt = otp_r;          pd_nxt = pd_r;
		wsr_nxt = wsr_r;        op_nxt = op_r;            pdat_nxt = pdat_r;
		swr_nxt = 1'b0;         opv_nxt = 1'b0;           pval_nxt = 1'b0;
		if (cs_fall)
		begin
			// new frame: counters back to the opcode
			state_nxt = ST_OPC;  bit_cnt_nxt = '0;  byte_cnt_nxt = '0;
			done_nxt  = 1'b0;    obit_nxt = '0;     idx_nxt = '0;
		end
		else if (cs_rise)
		begin
			// frame end: release pins, execute write-class commands
			state_nxt = ST_IDLE;
			drive_nxt = 1'b0;
			dual_nxt  = 1'b0;
			if (exec)
			begin
				op_nxt.addr = addr_r;
				op_nxt.otp  = otp_r;
				case (opc_r)
					`OPC_WRITE_LATCH_ARM:   wl_nxt = 1'b1;
					`OPC_WRITE_LATCH_CLEAR: wl_nxt = 1'b0;
					`OPC_STATUS_WRITE:
						if (wl_r)
						begin
							swr_nxt = 1'b1;
							wl_nxt  = 1'b0;
						end
					`OPC_FOUR_KIB_WIPE, `OPC_BLOCK_WIPE_A, `OPC_BLOCK_WIPE_B,
					`OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B, `OPC_PAGE_WRITE:
						if (wl_r)
						begin
							opv_nxt = 1'b1;
							wl_nxt  = 1'b0;
							case (opc_r)
								`OPC_FOUR_KIB_WIPE: op_nxt.kind = OP_SECTOR_WIPE;
								`OPC_PAGE_WRITE:    op_nxt.kind = OP_PAGE_WRITE;
								`OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B:
									op_nxt.kind = OP_CHIP_WIPE;
								default:            op_nxt.kind = OP_BLOCK_WIPE;
							endcase
						end
					`OPC_LOCKDOWN_BIT:    lock_nxt = 1'b1;
					`OPC_OTP_ENTRY:       otp_nxt = 1'b1;
					`OPC_OTP_EXIT:        otp_nxt = 1'b0;
					`OPC_DEEP_POWER_DOWN: pd_nxt = 1'b1;
					`OPC_WAKE_SIGNATURE:  pd_nxt = 1'b0;
					default: ;
				endcase
			end
		end
		else
		begin
			if (sclk_rise)
			begin
				bit_cnt_nxt = 3'(bit_cnt_r + 3'd1);
				sh_in_nxt   = sh_full;
			end
			if (byte_done)
			begin
				case (state_r)
					ST_OPC:
					begin
						opc_nxt = sh_full;
						if (pd_r && sh_full != `OPC_WAKE_SIGNATURE)
							state_nxt = ST_IGNORE;
						else
							case (sh_full)
								`OPC_WRITE_LATCH_ARM, `OPC_WRITE_LATCH_CLEAR, `OPC_LOCKDOWN_BIT,
								`OPC_OTP_ENTRY, `OPC_OTP_EXIT, `OPC_DEEP_POWER_DOWN,
								`OPC_CHIP_WIPE_A, `OPC_CHIP_WIPE_B:
								begin
									done_nxt  = 1'b1;
									state_nxt = ST_TAIL;
								end
								`OPC_WAKE_SIGNATURE:
								begin
									done_nxt  = 1'b1;
									state_nxt = ST_ADDR;
								end
								`OPC_STATUS_WRITE:                           state_nxt = ST_DIN;
								`OPC_STATUS_READ, `OPC_JEDEC_ID_READ,
								`OPC_LOCKDOWN_READ:                          state_nxt = ST_DOUT;
								`OPC_ARRAY_READ, `OPC_FAST_READ, `OPC_DUAL_READ,
								`OPC_MAKER_PART_ID, `OPC_FOUR_KIB_WIPE,
								`OPC_BLOCK_WIPE_A, `OPC_BLOCK_WIPE_B,
								`OPC_PAGE_WRITE:                             state_nxt = ST_ADDR;
								default:                                     state_nxt = ST_IGNORE;
							endcase
					end
					ST_ADDR:
					begin
						// three address bytes, most significant first
						addr_nxt     = {addr_r[15:0], sh_full};
						byte_cnt_nxt = 2'(byte_cnt_r + 2'd1);
						if (byte_cnt_r == `ADDR_LAST_BYTE)
						begin
							op_nxt.addr = {addr_r[15:0], sh_full};
							op_nxt.otp  = otp_r;
							case (opc_r)
								`OPC_FAST_READ, `OPC_DUAL_READ:
								begin
									state_nxt   = ST_DUMMY;
									opv_nxt     = 1'b1;
									op_nxt.kind = (opc_r == `OPC_FAST_READ) ? OP_FAST_READ
										: OP_DUAL_READ;
								end
								`OPC_ARRAY_READ:
								begin
									state_nxt   = ST_DOUT;
									opv_nxt     = 1'b1;
									op_nxt.kind = OP_READ;
								end
								`OPC_PAGE_WRITE:
								begin
									done_nxt  = 1'b1;
									state_nxt = ST_DIN;
								end
								`OPC_FOUR_KIB_WIPE, `OPC_BLOCK_WIPE_A, `OPC_BLOCK_WIPE_B:
								begin
									done_nxt  = 1'b1;
									state_nxt = ST_TAIL;
								end
								default: state_nxt = ST_DOUT;
							endcase
						end
					end
					ST_DUMMY:
					begin
						state_nxt = ST_DOUT;
						dual_nxt  = (opc_r == `OPC_DUAL_READ);
					end
					ST_DIN:
						if (opc_r == `OPC_PAGE_WRITE)
						begin
							pdat_nxt = sh_full;
							pval_nxt = 1'b1;
						end
						else if (!done_r)
						begin
							wsr_nxt  = sh_full;
							done_nxt = 1'b1;
						end
					default: ;
				endcase
			end
			if (sclk_fall && state_r == ST_DOUT)
			begin
				// output shifts on the falling edge, msb first
				drive_nxt = 1'b1;
				if (obit_r == 3'd0)
				begin
					so_nxt   = next_byte[7];
					sio0_nxt = next_byte[6];
					out_sh_nxt = dual_r ? {next_byte[5:0], 2'b00} : {next_byte[6:0], 1'b0};
					idx_nxt  = (opc_r == `OPC_JEDEC_ID_READ && idx_r == `JEDEC_LAST_IDX) ? 2'd0
						: 2'(idx_r + 2'd1);
				end
				else
				begin
					so_nxt     = out_sh_r[7];
					sio0_nxt   = out_sh_r[6];
					out_sh_nxt = dual_r ? {out_sh_r[5:0], 2'b00} : {out_sh_r[6:0], 1'b0};
				end
				obit_nxt = (dual_r && obit_r == 3'd3) ? 3'd0 : 3'(obit_r + 3'd1);
			end
		end
	end

	// all registers
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			cs_sync_r <= 3'h7;  sclk_sync_r <= 3'h0;  si_sync_r <= 2'h0;
			state_r <= ST_IDLE; bit_cnt_r <= '0;  byte_cnt_r <= '0;  sh_in_r <= '0;
			opc_r <= '0;        addr_r <= '0;     done_r <= 1'b0;    out_sh_r <= '0;
			obit_r <= '0;       idx_r <= '0;      so_r <= 1'b0;      sio0_r <= 1'b0;
			drive_r <= 1'b0;    dual_r <= 1'b0;   wl_r <= `WRITE_LATCH_RST;
			lock_r <= `LOCKDOWN_RST;  otp_r <= 1'b0;  pd_r <= 1'b0;  wsr_r <= '0;
			swr_r <= 1'b0;      op_r <= '0;       opv_r <= 1'b0;     pdat_r <= '0;
			pval_r <= 1'b0;
		end
		else
		begin
			cs_sync_r <= {cs_sync_r[1:0], cs_n_i};
			sclk_sync_r <= {sclk_sync_r[1:0], sclk_i};
			si_sync_r <= {si_sync_r[0], si_i};
			state_r <= state_nxt;  bit_cnt_r <= bit_cnt_nxt;  byte_cnt_r <= byte_cnt_nxt;
			sh_in_r <= sh_in_nxt;  opc_r <= opc_nxt;  addr_r <= addr_nxt;  done_r <= done_nxt;
			out_sh_r <= out_sh_nxt;  obit_r <= obit_nxt;  idx_r <= idx_nxt;  so_r <= so_nxt;
			sio0_r <= sio0_nxt;  drive_r <= drive_nxt;  dual_r <= dual_nxt;  wl_r <= wl_nxt;
			lock_r <= lock_nxt;  otp_r <= otp_nxt;  pd_r <= pd_nxt;  wsr_r <= wsr_nxt;
			swr_r <= swr_nxt;  op_r <= op_nxt;  opv_r <= opv_nxt;  pdat_r <= pdat_nxt;
			pval_r <= pval_nxt;
		end
	end

	// outputs
	assign so_o          = so_r;
	assign so_oe_o       = drive_r;
	assign sio0_o        = sio0_r;
	assign sio0_oe_o     = drive_r && dual_r;
	assign write_latch_o = wl_r;
	assign lockdown_o    = lock_r;
	assign otp_mode_o    = otp_r;
	assign deep_pd_o     = pd_r;
	assign op_o          = op_r;
	assign op_valid_o    = opv_r;
	assign prog_data_o   = pdat_r;
	assign prog_valid_o  = pval_r;
	assign status_wr_o   = swr_r;
	assign status_data_o = wsr_r;

	// checks
	a_latch_arm_exec: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		exec && opc_r == `OPC_WRITE_LATCH_ARM |=> wl_r) else $error("latch not armed");
	a_latch_clear_exec: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		exec && opc_r == `OPC_WRITE_LATCH_CLEAR |=> !wl_r) else $error("latch not cleared");
	a_latch_drop_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		swr_r || (opv_r && op_r.kind >= OP_PAGE_WRITE) |-> !wl_r) else $error("latch kept");
	a_write_needs_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		swr_r || (opv_r && op_r.kind >= OP_PAGE_WRITE) |-> $past(wl_r))
		else $error("write without latch");
	a_lock_stays_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		lock_r |=> lock_r [*3]) else $error("lock-down bit cleared");
	a_otp_entry_exec: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		exec && opc_r == `OPC_OTP_ENTRY |=> otp_r ##1 $stable(otp_r) || cs_rise)
		else $error("otp mode not entered");
	a_wake_clears_pd: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		exec && opc_r == `OPC_WAKE_SIGNATURE |=> !pd_r) else $error("no wake");
	a_pd_blocks_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		pd_r && $stable(pd_r) |=> wl_r == $past(wl_r)) else $error("latch moved in power-down");
	a_boundary_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(wl_r) |-> $past(bit_cnt_r) == 3'd0 && $past(cs_rise)) else $error("unaligned exec");
	a_shift_on_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$changed(so_r) |-> $past(sclk_fall)) else $error("output moved off falling edge");
	a_chip_wipe_op: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		exec && wl_r && opc_r == `OPC_CHIP_WIPE_A |=> opv_r && op_r.kind == OP_CHIP_WIPE)
		else $error("chip wipe not issued");
	a_dummy_fast_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		state_r == ST_DUMMY |-> opc_r == `OPC_FAST_READ || opc_r == `OPC_DUAL_READ)
		else $error("dummy byte on wrong opcode");
	a_maker_part_id_cmd_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		sclk_fall && state_r == ST_DOUT && obit_r == 3'd0 && opc_r == `OPC_MAKER_PART_ID
		&& idx_r == 2'd0 |-> next_byte == (addr_r[0] ? ID_PART : ID_MAKER))
		else $error("maker/part order wrong");

endmodule : flash_cmd_decoder

// ==== bench/spi_host_model.sv ====
/* spi_host_model: mode 0 host, 125 ns serial clock, one frame per call.
   assumes: clk_i is the 200 MHz system clock. */
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      si_o
);
	logic [7:0] tx [20];  // bytes to send
	logic [7:0] rx [20];  // bytes seen on so
	// idle: deselected, clock low
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o   = 1'b0;
		foreach (tx[i]) tx[i] = 8'h00;
	end
	// msb first; hold keeps select low for a later call
	task automatic frame(input int nbits, input bit hold);
		cs_n_o <= 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			si_o <= tx[i/8][7-i%8];
			repeat (12) @(posedge clk_i);
			sclk_o <= 1'b1;
			rx[i/8][7-i%8] <= so_i;
			repeat (13) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (12) @(posedge clk_i);
		if (!hold)
			cs_n_o <= 1'b1;
		si_o <= ~si_o;  // released line must not keep its value
		repeat (6) @(posedge clk_i);
	endtask : frame
endmodule : spi_host_model

// ==== bench/tb.sv ====
/* tb: random and corner frames into the flash command decoder.
   assumes: the bench plays the array side and fills the read fifo. */
`timescale 1ns/1ps
module tb import flash_cmd_pkg::*;;
	localparam logic [7:0] MK = 8'h3c;  // arbitrary value
	localparam logic [7:0] PT = 8'h7e;  // arbitrary value
	localparam logic [7:0] TY = 8'h41;  // arbitrary value
	localparam logic [7:0] CP = 8'h52;  // arbitrary value
	localparam logic [7:0] SG = 8'h6d;  // arbitrary value
	logic sys_clk_i, rst_n_i, cs_n_i, sclk_i, si_i, so_o, rdy;
	logic factory_lock_i, write_latch_o, lockdown_o, otp_mode_o, deep_pd_o;
	logic op_valid_o, rd_valid_i, rd_ready_o, status_wr_o, prog_valid_o;
	logic [7:0] status_ext_i, rd_data_i, d, status_data_o, prog_data_o, pdat_seen;
	logic [7:0] q [16];
	logic [31:0] a;
	op_s op_o, op_seen;
	int errors, num_checks, op_cnt, nop, n, sw_cnt;
	logic [7:0] wop [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
	op_kind_e wk [5] = '{OP_SECTOR_WIPE, OP_BLOCK_WIPE, OP_BLOCK_WIPE, OP_CHIP_WIPE, OP_CHIP_WIPE};
	logic [7:0] rop [3] = '{8'h03, 8'h0b, 8'h3b};
	op_kind_e rk [3] = '{OP_READ, OP_FAST_READ, OP_DUAL_READ};
	// 200 MHz clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	flash_cmd_decoder #(.ID_MAKER(MK), .ID_TYPE(TY), .ID_CAP(CP), .ID_PART(PT),
		.ID_SIG(SG)) i_flash_cmd_decoder (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
		.si_i(si_i), .so_o(so_o), .so_oe_o(), .sio0_o(), .sio0_oe_o(),
		.factory_lock_i(factory_lock_i), .status_ext_i(status_ext_i),
		.write_latch_o(write_latch_o), .lockdown_o(lockdown_o), .otp_mode_o(otp_mode_o),
		.deep_pd_o(deep_pd_o), .op_o(op_o), .op_valid_o(op_valid_o),
		.prog_data_o(prog_data_o), .prog_valid_o(prog_valid_o), .status_wr_o(status_wr_o),
		.status_data_o(status_data_o), .rd_data_i(rd_data_i),
		.rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o));
	spi_host_model i_spi_host_model (.clk_i(sys_clk_i), .so_i(so_o), .cs_n_o(cs_n_i),
		.sclk_o(sclk_i), .si_o(si_i));
	// catch issued operations
	always @(posedge sys_clk_i)
	begin
		if (op_valid_o === 1'b1)
		begin
			op_seen <= op_o;
			op_cnt  <= op_cnt + 1;
		end
		if (status_wr_o === 1'b1)
			sw_cnt <= sw_cnt + 1;
		if (prog_valid_o === 1'b1)
			pdat_seen <= prog_data_o;
	end
	function automatic logic [7:0] stat_exp(logic [7:0] ext, logic wl);
		return {ext[7:2], wl, ext[0]};
	endfunction : stat_exp
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// load up to four bytes and run one frame
	task automatic run(input logic [31:0] w, input int nb, input int xb, input bit hold);
		for (int i = 0; i < 4; i++)
			i_spi_host_model.tx[i] = w[31-8*i -: 8];
		i_spi_host_model.frame(nb * 8 + xb, hold);
	endtask : run
	// bounded wait for the k-th operation
	task automatic wait_op(input int k);
		for (int t = 0; t < 60 && op_cnt != k; t++)
			@(posedge sys_clk_i);
		chk("op_count", k, op_cnt);
		if (op_cnt != k)
			test_done();
	endtask : wait_op
	// push random bytes until the fifo refuses
	task automatic fill();
		n = 0;
		for (int k = 0; k < 20; k++)
		begin
			d = $urandom;
			rd_data_i  <= d;
			rd_valid_i <= 1'b1;
			@(negedge sys_clk_i);
			rdy = rd_ready_o;
			@(posedge sys_clk_i);
			if (!rdy)
				break;
			q[n % 16] = d;
			n++;
		end
		rd_valid_i <= 1'b0;
	endtask : fill
	initial
	begin
		errors = 0;
		num_checks = 0;
		nop = 0;
		rst_n_i = 1'b0;
		rd_valid_i = 1'b0;
		rd_data_i = 8'h00;
		void'($urandom(32'hf87a74fa));
		status_ext_i = $urandom;
		factory_lock_i = $urandom;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		chk("latch_rst", 0, write_latch_o);
		run(32'h20123456, 4, 0, 0);
		wait_op(nop);
		run(32'h06000000, 1, 0, 0);
		chk("latch_set", 1, write_latch_o);
		run(32'h05000000, 2, 0, 0);
		chk("status", stat_exp(status_ext_i, 1'b1), i_spi_host_model.rx[1]);
		run(32'h60000000, 1, 3, 0);
		wait_op(nop);
		chk("latch_kept", 1, write_latch_o);
		run(32'h04000000, 1, 0, 0);
		chk("latch_clr", 0, write_latch_o);
		foreach (wop[i])
		begin
			run(32'h06000000, 1, 0, 0);
			a = $urandom;
			run({wop[i], a[23:0]}, (i > 2) ? 1 : 4, 0, 0);
			wait_op(++nop);
			chk("wipe_kind", wk[i], op_seen.kind);
			if (i <= 2)
				chk("wipe_addr", a[23:0], op_seen.addr);
			chk("wipe_otp", 0, op_seen.otp);
			chk("latch_done", 0, write_latch_o);
		end
		// page program: address, one data byte, aligned end
		run(32'h06000000, 1, 0, 0);
		a = $urandom;
		run({8'h02, a[23:0]}, 4, 0, 1'b1);
		run(a, 1, 0, 0);
		wait_op(++nop);
		chk("pp_kind", OP_PAGE_WRITE, op_seen.kind);
		chk("pp_addr", a[23:0], op_seen.addr);
		chk("pp_data", a[31:24], pdat_seen);
		chk("latch_pp", 0, write_latch_o);
		// status write with latch, then without
		run(32'h06000000, 1, 0, 0);
		a = $urandom;
		run({8'h01, a[7:0], 16'h0000}, 2, 0, 0);
		chk("swr_cnt", 1, sw_cnt);
		chk("swr_data", a[7:0], status_data_o);
		chk("latch_swr", 0, write_latch_o);
		run({8'h01, a[15:8], 16'h0000}, 2, 0, 0);
		chk("swr_refused", 1, sw_cnt);
		foreach (rop[i])
		begin
			a = $urandom;
			run({rop[i], a[23:0]}, 4, 0, 1'b1);
			wait_op(++nop);
			chk("rd_kind", rk[i], op_seen.kind);
			chk("rd_addr", a[23:0], op_seen.addr);
			if (i == 1)
				fill();
			if (i == 1)
				chk("fifo_fill", 16, n);
			run(0, (i == 1) ? 18 : 0, 0, 0);
			for (int k = 0; k < 16 && i == 1; k++)
				chk("rd_byte", q[k], i_spi_host_model.rx[k+1]);
			if (i == 1)
				chk("rd_under", 8'hff, i_spi_host_model.rx[17]);
		end
		for (int k = 0; k < 2; k++)
		begin
			run({24'h900000, 8'(k)}, 6, 0, 0);
			chk("id_first", k ? PT : MK, i_spi_host_model.rx[4]);
			chk("id_second", k ? MK : PT, i_spi_host_model.rx[5]);
		end
		run(32'h9f000000, 4, 0, 0);
		chk("jedec", {MK, TY, CP}, {i_spi_host_model.rx[1], i_spi_host_model.rx[2],
			i_spi_host_model.rx[3]});
		run(32'hb1000000, 1, 0, 0);
		chk("otp_in", 1, otp_mode_o);
		run(32'hc1000000, 1, 0, 0);
		chk("otp_out", 0, otp_mode_o);
		run(32'h2f000000, 1, 0, 0);
		run(32'h2f000000, 1, 0, 0);
		chk("lock", 1, lockdown_o);
		run(32'h2b000000, 2, 0, 0);
		chk("sec_reg", {6'h00, 1'b1, factory_lock_i}, i_spi_host_model.rx[1]);
		run(32'h06000000, 1, 0, 0);
		run(32'hb9000000, 1, 0, 0);
		chk("pd_in", 1, deep_pd_o);
		run(32'h04000000, 1, 0, 0);
		chk("pd_ignore", 1, write_latch_o);
		run(32'hab000000, 1, 0, 0);
		chk("pd_out", 0, deep_pd_o);
		run(32'hab000000, 5, 0, 0);
		chk("signature", SG, i_spi_host_model.rx[4]);
		test_done();
	end
endmodule : tb
